// >>> hw/slscr_pkg.sv
// Package: register map, field layout and bus carriers for the link status/config bank
package slscr_pkg;
  localparam int unsigned ADDR_W = 12;
  // Offsets are word indexes, not byte addresses: byte address is four times each index
  localparam logic [ADDR_W-1:0] IDX_FRAME_COMMA = 12'h207;
  localparam logic [ADDR_W-1:0] IDX_LINK_STATUS = 12'h208;
  localparam logic [ADDR_W-1:0] IDX_CHAN_ENABLE = 12'h209;
  localparam logic [ADDR_W-1:0] IDX_LINK_CTRL = 12'h20a;
  localparam int unsigned BYTE_SHIFT = 2;
  localparam logic [7:0] RST_FRAME_COMMA = 8'h00;
  localparam logic [7:0] RST_LINK_STATUS = 8'h00;
  localparam logic [7:0] RST_CHAN_ENABLE = 8'h03;
  localparam logic [7:0] RST_LINK_CTRL = 8'h00;
  // Field positions
  localparam int unsigned ST_LINK_UP = 6;
  localparam int unsigned ST_SYNC = 5;
  localparam int unsigned ST_REALIGN = 4;
  localparam int unsigned ST_PHASE_SET = 3;
  localparam int unsigned ST_SERDES_LOCK = 2;
  localparam int unsigned ST_CONV_LOCK = 0;
  localparam int unsigned CE_ONE_CH = 2;
  localparam int unsigned CE_UPPER = 1;
  localparam int unsigned CE_LOWER = 0;
  localparam int unsigned LC_LINK_EN = 0;
  localparam int unsigned LC_CAL_EN = 1;
  localparam int unsigned LC_MODE_66 = 2;
  localparam int unsigned FC_SEL_W = 2;
  // Comma characters (10-bit-free K code byte values)
  localparam logic [7:0] K28_7 = 8'hfc;
  localparam logic [7:0] K28_1 = 8'h3c;
  localparam logic [7:0] K28_5 = 8'hbc;

  typedef enum logic [1:0] {
    SLSCR_COMMA_K287,
    SLSCR_COMMA_K281,
    SLSCR_COMMA_K285,
    SLSCR_COMMA_RSVD
  } slscr_comma_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } slscr_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } slscr_wb_rsp_s;

  typedef struct packed {
    logic link_up;
    logic sync_n;
    logic realign_evt;
    logic sysref_evt;
    logic serdes_pll_lock;
    logic converter_pll_lock;
  } slscr_link_stat_s;

  typedef struct packed {
    logic one_channel_mode;
    logic upper_pair_enable;
    logic lower_pair_enable;
  } slscr_chan_s;
endpackage : slscr_pkg

// >>> hw/slscr_regs.sv
// Register bank for link status, channel pair enables and end-of-frame comma selection
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Two-bit field picks end-of-frame comma: 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved.
// - Comma inserted only in 8B/10B modes; ignored in 64B/66B modes.
// - Status bit 6 high while the link is established.
// - Status bit 5 shows live sync level: 0 asserted, 1 deasserted.
// - Status bit 4 sets on clock realignment by SYSREF, cleared by writing 1.
// - Status bit 3 sets on first SYSREF after link enable, cleared by writing 1.
// - Status bit 2 high while SerDes PLL is locked.
// - Status bit 0 high while converter PLL is locked.
// - Link status at 0x208, resets to 0; bits 7 and 1 reserved.
// - Channel enable at 0x209 resets 0x03: bit2 single, bit1 upper, bit0 lower pair.
// - Single channel mode disables B, C, D; lower pair must stay enabled.
// - Each pair bit powers its two channels; clearing it disables them.
module slscr_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire slscr_pkg::slscr_wb_req_s wb_req_i,
  output slscr_pkg::slscr_wb_rsp_s wb_rsp_o,
  input wire slscr_pkg::slscr_link_stat_s link_i,
  output logic [7:0] comma_char_o,
  output logic comma_insert_en_o,
  output logic link_enable_o,
  output logic cal_enable_o,
  output logic mode_64b66b_o,
  output logic [3:0] channel_on_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic idx_hit(input logic [31:0] adr, input logic [slscr_pkg::ADDR_W-1:0] idx);
    idx_hit = (adr == {{(32 - slscr_pkg::ADDR_W - slscr_pkg::BYTE_SHIFT){1'b0}}, idx, 2'b00});
  endfunction : idx_hit

  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] fc_q;
  logic [7:0] st_q;
  logic [7:0] ce_q;
  logic [7:0] lc_q;
  logic link_en_d1_q;
  logic armed_q;
  logic [7:0] comma_q;
  logic insert_q;
  logic [3:0] chan_q;

  wire req = wb_req_i.cyc && wb_req_i.stb && !ack_q;
  wire wr = req && wb_req_i.we && wb_req_i.sel[0];
  wire hit_fc = idx_hit(wb_req_i.adr, slscr_pkg::IDX_FRAME_COMMA);
  wire hit_st = idx_hit(wb_req_i.adr, slscr_pkg::IDX_LINK_STATUS);
  wire hit_ce = idx_hit(wb_req_i.adr, slscr_pkg::IDX_CHAN_ENABLE);
  wire hit_lc = idx_hit(wb_req_i.adr, slscr_pkg::IDX_LINK_CTRL);
  wire [7:0] wbyte = wb_req_i.dat[7:0];
  wire [7:0] rsel;
  assign rsel = hit_fc ? fc_q : hit_st ? st_q : hit_ce ? ce_q : hit_lc ? lc_q : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone classic slave: one wait state, unmapped reads zero

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= req;
      rdat_q <= {24'h0, rsel};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fc_q <= slscr_pkg::RST_FRAME_COMMA;
      ce_q <= slscr_pkg::RST_CHAN_ENABLE;
      lc_q <= slscr_pkg::RST_LINK_CTRL;
    end else begin
      if (wr && hit_fc) begin
        fc_q <= wbyte;
      end
      if (wr && hit_ce) begin
        ce_q <= wbyte;
      end
      if (wr && hit_lc) begin
        lc_q <= wbyte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register

  wire link_en = lc_q[slscr_pkg::LC_LINK_EN];
  wire w1c_re = wr && hit_st && wbyte[slscr_pkg::ST_REALIGN];
  wire w1c_ph = wr && hit_st && wbyte[slscr_pkg::ST_PHASE_SET];
  wire phase_set = link_i.sysref_evt && armed_q;
  wire [7:0] st_d;
  assign st_d[7] = 1'b0;
  assign st_d[slscr_pkg::ST_LINK_UP] = link_i.link_up;
  assign st_d[slscr_pkg::ST_SYNC] = link_i.sync_n;
  assign st_d[slscr_pkg::ST_REALIGN] = link_i.realign_evt || (st_q[slscr_pkg::ST_REALIGN] && !w1c_re);
  assign st_d[slscr_pkg::ST_PHASE_SET] = phase_set || (st_q[slscr_pkg::ST_PHASE_SET] && !w1c_ph);
  assign st_d[slscr_pkg::ST_SERDES_LOCK] = link_i.serdes_pll_lock;
  assign st_d[1] = 1'b0;
  assign st_d[slscr_pkg::ST_CONV_LOCK] = link_i.converter_pll_lock;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= slscr_pkg::RST_LINK_STATUS;
      link_en_d1_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      st_q <= st_d;
      link_en_d1_q <= link_en;
      if (link_en && !link_en_d1_q) begin
        armed_q <= 1'b1;
      end else if (phase_set || !link_en) begin
        armed_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side outputs

  wire [1:0] fsel = fc_q[slscr_pkg::FC_SEL_W-1:0];
  wire [7:0] comma_d;
  assign comma_d = (fsel == 2'(slscr_pkg::SLSCR_COMMA_K281)) ? slscr_pkg::K28_1 :
                   (fsel == 2'(slscr_pkg::SLSCR_COMMA_K285)) ? slscr_pkg::K28_5 :
                   slscr_pkg::K28_7;
  wire insert_d = link_en && !lc_q[slscr_pkg::LC_MODE_66] && (fsel != 2'(slscr_pkg::SLSCR_COMMA_RSVD));
  wire one_ch = ce_q[slscr_pkg::CE_ONE_CH];
  wire [3:0] chan_d;
  assign chan_d[0] = ce_q[slscr_pkg::CE_LOWER];
  assign chan_d[1] = ce_q[slscr_pkg::CE_LOWER] && !one_ch;
  assign chan_d[2] = ce_q[slscr_pkg::CE_UPPER] && !one_ch;
  assign chan_d[3] = ce_q[slscr_pkg::CE_UPPER] && !one_ch;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comma_q <= slscr_pkg::K28_7;
      insert_q <= 1'b0;
      chan_q <= 4'hf;
    end else begin
      comma_q <= comma_d;
      insert_q <= insert_d;
      chan_q <= chan_d;
    end
  end

  assign wb_rsp_o.ack = ack_q;
  assign wb_rsp_o.dat = rdat_q;
  assign comma_char_o = comma_q;
  assign comma_insert_en_o = insert_q;
  assign link_enable_o = lc_q[slscr_pkg::LC_LINK_EN];
  assign cal_enable_o = lc_q[slscr_pkg::LC_CAL_EN];
  assign mode_64b66b_o = lc_q[slscr_pkg::LC_MODE_66];
  assign channel_on_o = chan_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_wr_flag_one(int b);
    wr && hit_st && wbyte[b];
  endsequence

  a_realign_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    link_i.realign_evt |=> st_q[slscr_pkg::ST_REALIGN]) else $error("realign flag not set");
  a_realign_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_wr_flag_one(slscr_pkg::ST_REALIGN) and !link_i.realign_evt) |=> !st_q[slscr_pkg::ST_REALIGN])
    else $error("realign flag not cleared");
  a_realign_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q[slscr_pkg::ST_REALIGN] && !w1c_re) |=> st_q[slscr_pkg::ST_REALIGN]) else $error("realign flag lost");
  a_phase_first: assert property (@(posedge clk_i) disable iff (rst_i)
    (link_en && !link_en_d1_q) ##1 (link_en && link_i.sysref_evt) |=> st_q[slscr_pkg::ST_PHASE_SET])
    else $error("phase flag not set");
  a_phase_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_wr_flag_one(slscr_pkg::ST_PHASE_SET) and !phase_set) |=> !st_q[slscr_pkg::ST_PHASE_SET])
    else $error("phase flag not cleared");
  a_live_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 st_q[slscr_pkg::ST_LINK_UP] == $past(link_i.link_up) && st_q[slscr_pkg::ST_SYNC] == $past(link_i.sync_n))
    else $error("live bits wrong");
  a_lock_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 st_q[slscr_pkg::ST_SERDES_LOCK] == $past(link_i.serdes_pll_lock)
    && st_q[slscr_pkg::ST_CONV_LOCK] == $past(link_i.converter_pll_lock)) else $error("lock bits wrong");
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_q[7] && !st_q[1]) else $error("reserved status bit set");
  a_one_channel: assert property (@(posedge clk_i) disable iff (rst_i)
    one_ch |=> chan_q[3:1] == 3'b000) else $error("single mode leaves channels on");
  a_comma_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    lc_q[slscr_pkg::LC_MODE_66] |=> !comma_insert_en_o) else $error("comma in 64b66b mode");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> ack_q ##1 !ack_q) else $error("ack not single cycle");

  ////////////////////////////////////////////////////////////////////////////
  // Bus, field and output checks

  sequence s_read_of(logic hit);
    req && !wb_req_i.we && hit;
  endsequence

  sequence s_write_of(logic hit);
    wr && hit;
  endsequence

  sequence s_enable_rise;
    link_en && !link_en_d1_q;
  endsequence

  sequence s_unmapped;
    req && !hit_fc && !hit_st && !hit_ce && !hit_lc;
  endsequence

  a_ack_no_req: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> !ack_q) else $error("ack without request");

  a_read_lane: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_q |-> wb_rsp_o.dat[31:8] == 24'h0) else $error("upper read lanes not zero");

  a_read_status: assert property (@(posedge clk_i) disable iff (rst_i)
    s_read_of(hit_st) |=> wb_rsp_o.dat[7:0] == $past(st_q)) else $error("status read wrong");

  a_read_channel: assert property (@(posedge clk_i) disable iff (rst_i)
    s_read_of(hit_ce) |=> wb_rsp_o.dat[7:0] == $past(ce_q)) else $error("channel read wrong");

  a_read_comma: assert property (@(posedge clk_i) disable iff (rst_i)
    s_read_of(hit_fc) |=> wb_rsp_o.dat[7:0] == $past(fc_q)) else $error("comma select read wrong");

  a_read_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    s_unmapped |=> wb_rsp_o.dat == 32'h0) else $error("unmapped read not zero");

  a_fc_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_write_of(hit_fc) |=> fc_q == $past(wbyte)) else $error("comma select write lost");

  a_ce_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_write_of(hit_ce) |=> ce_q == $past(wbyte)) else $error("channel write lost");

  a_lc_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_write_of(hit_lc) |=> lc_q == $past(wbyte)) else $error("link control write lost");

  a_fc_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit_fc) |=> $stable(fc_q)) else $error("comma select changed without write");

  a_ce_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit_ce) |=> $stable(ce_q)) else $error("channel enable changed without write");

  a_lane_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_req_i.we && !wb_req_i.sel[0]) |=> $stable(ce_q) && $stable(fc_q))
    else $error("write without lane zero taken");

  a_comma_k281: assert property (@(posedge clk_i) disable iff (rst_i)
    fsel == 2'(slscr_pkg::SLSCR_COMMA_K281) |=> comma_char_o == slscr_pkg::K28_1)
    else $error("comma code one wrong");

  a_comma_k285: assert property (@(posedge clk_i) disable iff (rst_i)
    fsel == 2'(slscr_pkg::SLSCR_COMMA_K285) |=> comma_char_o == slscr_pkg::K28_5)
    else $error("comma code two wrong");

  a_comma_default: assert property (@(posedge clk_i) disable iff (rst_i)
    fsel == 2'(slscr_pkg::SLSCR_COMMA_K287) |=> comma_char_o == slscr_pkg::K28_7)
    else $error("comma code zero wrong");

  a_comma_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
    fsel == 2'(slscr_pkg::SLSCR_COMMA_RSVD) |=> !comma_insert_en_o) else $error("reserved code inserts");

  a_insert_on: assert property (@(posedge clk_i) disable iff (rst_i)
    (link_en && !lc_q[slscr_pkg::LC_MODE_66] && fsel != 2'(slscr_pkg::SLSCR_COMMA_RSVD)) |=> comma_insert_en_o)
    else $error("comma insertion missing");

  a_insert_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !link_en |=> !comma_insert_en_o) else $error("comma inserted while link off");

  a_link_up_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 st_q[slscr_pkg::ST_LINK_UP] == $past(link_i.link_up)) else $error("link up bit wrong");

  a_sync_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 st_q[slscr_pkg::ST_SYNC] == $past(link_i.sync_n)) else $error("sync bit wrong");

  a_serdes_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 st_q[slscr_pkg::ST_SERDES_LOCK] == $past(link_i.serdes_pll_lock)) else $error("serdes lock bit wrong");

  a_conv_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 st_q[slscr_pkg::ST_CONV_LOCK] == $past(link_i.converter_pll_lock)) else $error("converter lock bit wrong");

  a_realign_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (link_i.realign_evt && w1c_re) |=> st_q[slscr_pkg::ST_REALIGN]) else $error("realign lost to clear");

  a_phase_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (phase_set && w1c_ph) |=> st_q[slscr_pkg::ST_PHASE_SET]) else $error("phase flag lost to clear");

  a_phase_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q[slscr_pkg::ST_PHASE_SET] && !w1c_ph) |=> st_q[slscr_pkg::ST_PHASE_SET]) else $error("phase flag lost");

  a_phase_unarmed: assert property (@(posedge clk_i) disable iff (rst_i)
    (!armed_q && !st_q[slscr_pkg::ST_PHASE_SET]) |=> !st_q[slscr_pkg::ST_PHASE_SET])
    else $error("phase flag set while unarmed");

  a_arm_on_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    s_enable_rise |=> armed_q) else $error("not armed on enable");

  a_disarm_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !link_en |=> !armed_q) else $error("armed while link off");

  a_lower_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 channel_on_o[0] == $past(ce_q[slscr_pkg::CE_LOWER])) else $error("channel A wrong");

  a_lower_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_q[slscr_pkg::CE_LOWER] |=> channel_on_o[1:0] == 2'b00) else $error("lower pair not off");

  a_upper_on: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_q[slscr_pkg::CE_UPPER] && !one_ch) |=> channel_on_o[3:2] == 2'b11) else $error("upper pair not on");

  a_upper_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_q[slscr_pkg::CE_UPPER] |=> channel_on_o[3:2] == 2'b00) else $error("upper pair not off");

  a_single_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    (one_ch && ce_q[slscr_pkg::CE_LOWER]) |=> channel_on_o[0]) else $error("single channel not on");

endmodule : slscr_regs
`default_nettype wire

// >>> verif/slscr_link_model.sv
// Far-side link model driving status levels and event pulses
`timescale 1ns/1ps
`default_nettype none
module slscr_link_model (
  input wire logic clk_i,
  output var slscr_pkg::slscr_link_stat_s link_o
);
  initial link_o = '0;
  ////////////////////////////////////////////////////////////////
  task automatic set_lv(input logic up, input logic sn, input logic sp, input logic cp);
    @(posedge clk_i);
    link_o.link_up <= up;
    link_o.sync_n <= sn;
    link_o.serdes_pll_lock <= sp;
    link_o.converter_pll_lock <= cp;
  endtask : set_lv
  // One-cycle pulse of realign or sysref event
  task automatic pulse(input logic realign);
    @(posedge clk_i);
    if (realign) begin
      link_o.realign_evt <= 1'b1;
    end else begin
      link_o.sysref_evt <= 1'b1;
    end
    @(posedge clk_i);
    link_o.realign_evt <= 1'b0;
    link_o.sysref_evt <= 1'b0;
  endtask : pulse
endmodule : slscr_link_model
`default_nettype wire

// >>> verif/slscr_regs_tb.sv
// Testbench for the link status and configuration register bank
`timescale 1ns/1ps
`default_nettype none
module slscr_regs_tb;
  localparam logic [11:0] FC = slscr_pkg::IDX_FRAME_COMMA;
  localparam logic [11:0] ST = slscr_pkg::IDX_LINK_STATUS;
  localparam logic [11:0] CE = slscr_pkg::IDX_CHAN_ENABLE;
  localparam logic [11:0] LC = slscr_pkg::IDX_LINK_CTRL;
  localparam logic [7:0] COMMA_TAB [4] = '{slscr_pkg::K28_7, slscr_pkg::K28_1, slscr_pkg::K28_5, slscr_pkg::K28_7};
  localparam logic [7:0] CH_WR [4] = '{8'h03, 8'h01, 8'h02, 8'h05};
  localparam logic [7:0] CH_ON [4] = '{8'h0f, 8'h03, 8'h0c, 8'h01};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  slscr_pkg::slscr_wb_req_s req = '0;
  slscr_pkg::slscr_wb_rsp_s rsp;
  slscr_pkg::slscr_link_stat_s lnk;
  logic [7:0] comma;
  logic ins, len, cen, m66;
  logic [3:0] chon;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  slscr_regs uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .link_i(lnk),
    .comma_char_o(comma), .comma_insert_en_o(ins), .link_enable_o(len), .cal_enable_o(cen),
    .mode_64b66b_o(m66), .channel_on_o(chon));
  slscr_link_model far (.clk_i(clk_i), .link_o(lnk));
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [11:0] idx, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: {18'h0, idx, 2'b00}, dat: {24'h0, d}};
    do @(posedge clk_i); while (rsp.ack !== 1'b1);
    q = rsp.dat[7:0];
    req <= '0;
  endtask : wb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rc
  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask : settle
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(ST, 8'h00);
    rc(CE, 8'h03);
    rc(FC, 8'h00);
    chk({4'h0, chon}, 8'h0f);
    for (int c = 0; c < 4; c++) begin
      wr(LC, 8'h00);
      wr(FC, 8'(c));
      settle();
      chk(comma, COMMA_TAB[c]);
      rc(FC, 8'(c));
      wr(LC, 8'h01);
      settle();
      chk({7'h0, ins}, {7'h0, c != 3});
      wr(LC, 8'h05);
      settle();
      chk({7'h0, ins}, 8'h00);
      chk({5'h0, m66, cen, len}, 8'h05);
    end
    wr(LC, 8'h02);
    settle();
    chk({5'h0, m66, cen, len}, 8'h02);
    wr(LC, 8'h00);
    wr(FC, 8'h00);
    far.set_lv(1'b1, 1'b1, 1'b1, 1'b1);
    settle();
    rc(ST, 8'h65);
    far.set_lv(1'b1, 1'b0, 1'b1, 1'b0);
    settle();
    rc(ST, 8'h44);
    wr(ST, 8'hff);
    rc(ST, 8'h44);
    far.pulse(1'b1);
    settle();
    rc(ST, 8'h54);
    wr(ST, 8'h10);
    rc(ST, 8'h44);
    far.pulse(1'b0);
    settle();
    rc(ST, 8'h44);
    wr(LC, 8'h01);
    far.pulse(1'b0);
    settle();
    rc(ST, 8'h4c);
    wr(ST, 8'h08);
    far.pulse(1'b0);
    settle();
    rc(ST, 8'h44);
    wr(LC, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(CE, CH_WR[i]);
      settle();
      chk({4'h0, chon}, CH_ON[i]);
    end
    rc(12'h300, 8'h00);
    final_report();
  end
endmodule : slscr_regs_tb
`default_nettype wire
